/* File: hw/iops_top.sv */
// Contract
// - Latch register write acts exactly like port register write.
// - Latch read returns stored latch; port read returns pin levels.
// - Direction 1 makes pin input; 0 drives the latch value.
// - Port A pin five never drives; its direction bit reads 1.
// - Port A has eight direction and level bits; its latch has seven, none for pin five.
// - Port write reads pins, merges written bits, stores into latch.
// - Analog-selected pins read as 0 on digital reads.
// - Direction still gates the driver of an analog pin.
// - Steering bits never change direction; overrides follow the function.
// - Unselected pin behaves as if the function were absent.
// - Steer0 bit 7 moves serial receive between pb_pin1 and pb_pin2.
// - Steer0 bit 6 moves SPI data out between pb_pin2 and pa_pin6.
// - Steer0 bit 5 moves SPI slave select between pb_pin5 and pa_pin5.
// - Steer0 bit 4 moves PWM2 B between pb_pin7 and pa_pin6.
// - Steer0 bit 3 moves capture2 A between pb_pin6 and pa_pin7.
// - Steer0 bit 2 moves PWM1 D between pb_pin7 and pa_pin6.
// - Steer0 bit 1 moves PWM1 C between pb_pin6 and pa_pin7.
// - Steer0 bit 0 moves capture1 A between pb_pin3 and pb_pin0.
// - Steer1 bit 0 moves serial transmit between pb_pin2 and pb_pin5.
// - An enabled peripheral takes its pin from the port.
// - Highest priority output function drives a shared pin.
// - Analog select disables the digital input buffer.
//
// Register access over AHB-Lite and the register offsets were decided locally.
module iops_top
   import iops_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] pa_pin_in,
   output logic [7:0] pa_pin_out,
   output logic [7:0] pa_pin_oe,
   output logic [4:0] pa_digital_in_en,
   input wire logic [7:0] pb_pin_in,
   output logic [7:0] pb_pin_out,
   output logic [7:0] pb_pin_oe,
   input wire logic serial_rx_en,
   input wire logic serial_rx_oe,
   input wire logic serial_rx_out,
   output logic usart_rx_or_sync_data,
   input wire logic serial_tx_en,
   input wire logic serial_tx_oe,
   input wire logic serial_tx_out,
   output logic usart_tx_or_sync_clock,
   input wire logic spi1_out_en,
   input wire logic spi1_data_out,
   input wire logic spi1_select_en,
   output logic spi1_slave_select,
   input wire logic pwm2_b_en,
   input wire logic pwm2_out_b,
   input wire logic capture2_en,
   input wire logic capture2_oe,
   input wire logic capture2_out,
   output logic capture_pwm2_out_a,
   input wire logic pwm1_d_en,
   input wire logic pwm1_out_d,
   input wire logic pwm1_c_en,
   input wire logic pwm1_out_c,
   input wire logic capture1_en,
   input wire logic capture1_oe,
   input wire logic capture1_out,
   output logic capture_pwm1_out_a
);

   // A single stage would feed metastable levels into the read path.
   if (SYNC_STAGES < 2 || SYNC_STAGES > 4) begin : g_bad_stages
      $error("SYNC_STAGES must lie between 2 and 4.");
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   logic dp_write;
   logic dp_read;
   logic [IOPS_AW-1:0] dp_addr;
   logic [31:0] next_rdata;
   logic [7:0] pa_dir;
   logic [7:0] pa_latch;
   logic [4:0] pa_ansel;
   logic [7:0] pb_dir;
   logic [7:0] pb_latch;
   logic [7:0] steer0;
   logic steer1;
   logic [15:0] sync_q [SYNC_STAGES];
   logic [7:0] pa_sync;
   logic [7:0] pb_sync;
   logic [7:0] pa_level_rd;
   logic [7:0] next_pa_out;
   logic [7:0] next_pa_oe;
   logic [7:0] next_pb_out;
   logic [7:0] next_pb_oe;
   logic take;

   // Address phase is taken only while the bus is ready.
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign hresp = HRESP_OKAY;
   // Reads insert one wait state so read data comes from a flip-flop.
   assign hreadyout = !dp_read;

   // Data phase bookkeeping.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= '0;
      end else begin
         dp_write <= take && hwrite;
         dp_read <= take && !hwrite;
         if (take) begin
            dp_addr <= haddr[IOPS_AW-1:0];
         end
      end
   end

   // Pin inputs pass the synchroniser chain before any logic reads them.
   // level synchroniser
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sync_q[0] <= 16'h0000;
      end else begin
         sync_q[0] <= {pb_pin_in, pa_pin_in};
      end
   end

   for (genvar s = 1; s < SYNC_STAGES; s++) begin : g_sync
      always_ff @(posedge core_clk) begin
         if (!rstn) begin
            sync_q[s] <= 16'h0000;
         end else begin
            sync_q[s] <= sync_q[s-1];
         end
      end
   end

   assign pa_sync = sync_q[SYNC_STAGES-1][7:0];
   assign pb_sync = sync_q[SYNC_STAGES-1][15:8];

   // Analog pins read as zero on every digital read.
   // analog reads zero
   assign pa_level_rd = pa_sync & ~{3'h0, pa_ansel};

   // Port A latch, written through either the latch or the level register.
   // eight bit port
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pa_latch <= LATCH_RST;
      end else if (dp_write && dp_addr == PA_LATCH_ADDR) begin
         pa_latch <= hwdata[7:0] & PA_LATCH_IMPL;
      end else if (dp_write && dp_addr == PA_LEVEL_ADDR) begin
         pa_latch <= ((pa_level_rd & ~PORT_WR_MASK)
                      | (hwdata[7:0] & PORT_WR_MASK)) & PA_LATCH_IMPL;
      end
   end

   // Port A direction; pin five stays an input.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pa_dir <= DIR_RST;
      end else if (dp_write && dp_addr == PA_DIR_ADDR) begin
         pa_dir <= hwdata[7:0] | PA_DIR_FORCE;
      end
   end

   // Analog select drives the digital input buffer enables.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pa_ansel <= ANSEL_RST;
      end else if (dp_write && dp_addr == PA_ANSEL_ADDR) begin
         pa_ansel <= hwdata[4:0];
      end
   end

   assign pa_digital_in_en = ~pa_ansel;

   // Port B latch and direction, the fallback owner of steered pins.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pb_latch <= LATCH_RST;
         pb_dir <= DIR_RST;
      end else if (dp_write) begin
         if (dp_addr == PB_LATCH_ADDR) begin
            pb_latch <= hwdata[7:0];
         end else if (dp_addr == PB_LEVEL_ADDR) begin
            pb_latch <= (pb_sync & ~PORT_WR_MASK)
                        | (hwdata[7:0] & PORT_WR_MASK);
         end else if (dp_addr == PB_DIR_ADDR) begin
            pb_dir <= hwdata[7:0];
         end
      end
   end

   // Steering registers; they touch no direction bit.
   // steering independent
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         steer0 <= STEER0_RST;
         steer1 <= STEER1_RST;
      end else if (dp_write && dp_addr == STEER0_ADDR) begin
         steer0 <= hwdata[7:0];
      end else if (dp_write && dp_addr == STEER1_ADDR) begin
         steer1 <= hwdata[TX_SEL];
      end
   end

   // Read multiplexer; unmapped offsets read zero.
   always_comb begin
      next_rdata = 32'h00000000;
      case (dp_addr)
         PA_LEVEL_ADDR: next_rdata[7:0] = pa_level_rd;
         PA_LATCH_ADDR: next_rdata[7:0] = pa_latch;
         PA_DIR_ADDR: next_rdata[7:0] = pa_dir;
         PA_ANSEL_ADDR: next_rdata[4:0] = pa_ansel;
         STEER0_ADDR: next_rdata[7:0] = steer0;
         STEER1_ADDR: next_rdata[TX_SEL] = steer1;
         PB_LEVEL_ADDR: next_rdata[7:0] = pb_sync;
         PB_LATCH_ADDR: next_rdata[7:0] = pb_latch;
         PB_DIR_ADDR: next_rdata[7:0] = pb_dir;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Read data is captured in the wait cycle and then held.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hrdata <= 32'h00000000;
      end else if (dp_read) begin
         hrdata <= next_rdata;
      end
   end

   // Pin drive: port default first, lower priority overrides before
   // higher ones so the last assignment wins.
   always_comb begin
      next_pa_out = pa_latch;
      next_pa_oe = ~pa_dir;
      next_pb_out = pb_latch;
      next_pb_oe = ~pb_dir;
      if (steer0[P2B_SEL] && pwm2_b_en) begin
         next_pa_out[6] = pwm2_out_b;
         next_pa_oe[6] = 1'b1;
      end
      if (!steer0[P2B_SEL] && pwm2_b_en) begin
         next_pb_out[7] = pwm2_out_b;
         next_pb_oe[7] = 1'b1;
      end
      if (steer0[P1D_SEL] && pwm1_d_en) begin
         next_pa_out[6] = pwm1_out_d;
         next_pa_oe[6] = 1'b1;
      end
      if (!steer0[P1D_SEL] && pwm1_d_en) begin
         next_pb_out[7] = pwm1_out_d;
         next_pb_oe[7] = 1'b1;
      end
      if (steer0[SPI1_DATA_OUT_SEL] && spi1_out_en) begin
         next_pa_out[6] = spi1_data_out;
         next_pa_oe[6] = 1'b1;
      end
      if (!steer0[SPI1_DATA_OUT_SEL] && spi1_out_en) begin
         next_pb_out[2] = spi1_data_out;
         next_pb_oe[2] = 1'b1;
      end
      if (steer0[P1C_SEL] && pwm1_c_en) begin
         next_pa_out[7] = pwm1_out_c;
         next_pa_oe[7] = 1'b1;
      end
      if (!steer0[P1C_SEL] && pwm1_c_en) begin
         next_pb_out[6] = pwm1_out_c;
         next_pb_oe[6] = 1'b1;
      end
      if (steer0[CAP2_SEL] && capture2_en) begin
         next_pa_out[7] = capture2_out;
         next_pa_oe[7] = capture2_oe;
      end
      if (!steer0[CAP2_SEL] && capture2_en) begin
         next_pb_out[6] = capture2_out;
         next_pb_oe[6] = capture2_oe;
      end
      if (steer0[CAP1_SEL] && capture1_en) begin
         next_pb_out[0] = capture1_out;
         next_pb_oe[0] = capture1_oe;
      end
      if (!steer0[CAP1_SEL] && capture1_en) begin
         next_pb_out[3] = capture1_out;
         next_pb_oe[3] = capture1_oe;
      end
      if (!steer0[SS1_SEL] && spi1_select_en) begin
         next_pb_oe[5] = 1'b0;
      end
      if (!steer0[RX_SEL] && serial_rx_en) begin
         next_pb_out[1] = serial_rx_out;
         next_pb_oe[1] = serial_rx_oe;
      end
      if (steer0[RX_SEL] && serial_rx_en) begin
         next_pb_out[2] = serial_rx_out;
         next_pb_oe[2] = serial_rx_oe;
      end
      if (!steer1 && serial_tx_en) begin
         next_pb_out[2] = serial_tx_out;
         next_pb_oe[2] = serial_tx_oe;
      end
      if (steer1 && serial_tx_en) begin
         next_pb_out[5] = serial_tx_out;
         next_pb_oe[5] = serial_tx_oe;
      end
      next_pa_oe[PA_IN_ONLY] = 1'b0;
   end

   // Registered pin drive.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pa_pin_out <= LATCH_RST;
         pa_pin_oe <= 8'h00;
         pb_pin_out <= LATCH_RST;
         pb_pin_oe <= 8'h00;
      end else begin
         pa_pin_out <= next_pa_out;
         pa_pin_oe <= next_pa_oe;
         pb_pin_out <= next_pb_out;
         pb_pin_oe <= next_pb_oe;
      end
   end

   // Inputs to peripherals come only from the selected pin.
   // unselected pin free
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         usart_rx_or_sync_data <= 1'b0;
         usart_tx_or_sync_clock <= 1'b0;
         spi1_slave_select <= 1'b0;
         capture_pwm2_out_a <= 1'b0;
         capture_pwm1_out_a <= 1'b0;
      end else begin
         usart_rx_or_sync_data <= steer0[RX_SEL] ? pb_sync[2] : pb_sync[1];
         usart_tx_or_sync_clock <= steer1 ? pb_sync[5] : pb_sync[2];
         spi1_slave_select <= steer0[SS1_SEL] ? pa_sync[5] : pb_sync[5];
         capture_pwm2_out_a <= steer0[CAP2_SEL] ? pa_sync[7] : pb_sync[6];
         capture_pwm1_out_a <= steer0[CAP1_SEL] ? pb_sync[0] : pb_sync[3];
      end
   end

   a_latch_alias: assert property (
      dp_write && dp_addr == PA_LATCH_ADDR
      |=> pa_latch == ($past(hwdata[7:0]) & PA_LATCH_IMPL))
      else $error("Latch write not stored.");

   a_port_write_rmw: assert property (
      dp_write && dp_addr == PA_LEVEL_ADDR
      |=> pa_latch == ($past(hwdata[7:0]) & PA_LATCH_IMPL))
      else $error("Port write did not reach the latch.");

   a_analog_read_zero: assert property (
      dp_read && dp_addr == PA_LEVEL_ADDR
      |=> (hrdata[4:0] & $past(pa_ansel)) == 5'h00)
      else $error("Analog pin read as one.");

   a_pin5_input: assert property (
      !pa_pin_oe[PA_IN_ONLY] && pa_dir[PA_IN_ONLY])
      else $error("Pin five driven or direction cleared.");

   a_dir_drives_pin: assert property (
      ##1 pa_pin_oe[4:0] == ~$past(pa_dir[4:0])
      && pa_pin_out[4:0] == $past(pa_latch[4:0]))
      else $error("Driver does not follow direction.");

   a_steer_keeps_dir: assert property (
      dp_write && dp_addr == STEER0_ADDR
      |=> $stable(pa_dir) && $stable(pb_dir))
      else $error("Steering write changed a direction.");

   a_rx_on_pin1: assert property (
      !steer0[RX_SEL] && serial_rx_en && serial_rx_oe
      |=> pb_pin_oe[1] && pb_pin_out[1] == $past(serial_rx_out))
      else $error("Serial receive not on pb_pin1.");

   a_pa6_priority: assert property (
      steer0[SPI1_DATA_OUT_SEL] && spi1_out_en && steer0[P1D_SEL] && pwm1_d_en
      |=> pa_pin_oe[6] && pa_pin_out[6] == $past(spi1_data_out))
      else $error("Wrong function drives pa_pin6.");

   a_unselected_free: assert property (
      steer0[SPI1_DATA_OUT_SEL] && !(steer0[RX_SEL] && serial_rx_en)
      && !(!steer1 && serial_tx_en)
      |=> pb_pin_oe[2] == !$past(pb_dir[2]))
      else $error("Unselected pb_pin2 still overridden.");

   a_rx_sync_route: assert property (
      steer0[RX_SEL] [*4]
      |-> usart_rx_or_sync_data == $past(pb_pin_in[2], 3))
      else $error("Receive input not routed through synchroniser.");

   a_steer1_zero: assert property (
      dp_read && dp_addr == STEER1_ADDR |=> hrdata[31:1] == 31'h0)
      else $error("Steer1 upper bits not zero.");

endmodule : iops_top

/* File: hw/iops_pkg.sv */
package iops_pkg;
   // Register byte offsets on the bus.
   localparam int IOPS_AW = 8;
   localparam logic [7:0] PA_LEVEL_ADDR = 8'h00;
   localparam logic [7:0] PA_LATCH_ADDR = 8'h04;
   localparam logic [7:0] PA_DIR_ADDR = 8'h08;
   localparam logic [7:0] PA_ANSEL_ADDR = 8'h0c;
   localparam logic [7:0] STEER0_ADDR = 8'h10;
   localparam logic [7:0] STEER1_ADDR = 8'h14;
   localparam logic [7:0] PB_LEVEL_ADDR = 8'h18;
   localparam logic [7:0] PB_LATCH_ADDR = 8'h1c;
   localparam logic [7:0] PB_DIR_ADDR = 8'h20;
   // Widths and reset values.
   localparam int PORT_W = 8;
   localparam int ANSEL_W = 5;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [4:0] ANSEL_RST = 5'h1f;
   localparam logic [7:0] STEER0_RST = 8'h00;
   localparam logic STEER1_RST = 1'h0;
   // Pin five of port A has no driver and no latch bit.
   localparam int PA_IN_ONLY = 5;
   localparam logic [7:0] PA_LATCH_IMPL = 8'hdf;
   localparam logic [7:0] PA_DIR_FORCE = 8'h20;
   // Bits that one word write to a port level register modifies.
   localparam logic [7:0] PORT_WR_MASK = 8'hff;
   // Field positions in pin_steer_ctrl0 and pin_steer_ctrl1.
   localparam int RX_SEL = 7;
   localparam int SPI1_DATA_OUT_SEL = 6;
   localparam int SS1_SEL = 5;
   localparam int P2B_SEL = 4;
   localparam int CAP2_SEL = 3;
   localparam int P1D_SEL = 2;
   localparam int P1C_SEL = 1;
   localparam int CAP1_SEL = 0;
   localparam int TX_SEL = 0;
   // Bus encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage : iops_pkg

/* File: testbench/iops_pin_env.sv */
// Board-side model of the pins: an outside source and undriven lines.
module iops_pin_env (
   input wire logic core_clk,
   input wire logic [15:0] dev_out,
   input wire logic [15:0] dev_oe,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic flip = 1'b0;

   // A floating line toggles so that a stale value is never read as valid.
   always_ff @(posedge core_clk) begin
      flip <= ~flip;
   end

   // The device driver wins; otherwise the outside source; else floating.
   assign pin_in = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) |
      (~dev_oe & ~ext_en & {16{flip}});
endmodule : iops_pin_env

/* File: testbench/testbench.sv */
module testbench
   import iops_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, serial_rx_en = 1'b0, spi1_select_en = 1'b0;
   logic rx_oe = 1'b0;
   logic [7:0] pa_pin_out, pa_pin_oe, pb_pin_out, pb_pin_oe;
   logic [4:0] pa_digital_in_en;
   logic [6:0] fen = '0, fval = 7'h7f;
   logic [15:0] ext_en = '0, ext_val = '0, pin_in;
   logic rx_data, tx_clk, sel_in, cap2_in, cap1_in, insig;
   int n_errors = 0, compares = 0;
   int fb[7] = '{6, 4, 3, 2, 1, 0, 0};
   int p0[7] = '{10, 15, 14, 15, 14, 11, 10};
   int p1[7] = '{6, 6, 7, 6, 7, 8, 13};

   // Clock at 25 MHz.
   always #20 core_clk = ~core_clk;
   assign insig = spi1_select_en ? sel_in : rx_data;

   iops_top u_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .pa_pin_in(pin_in[7:0]),
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
      .pa_digital_in_en(pa_digital_in_en), .pb_pin_in(pin_in[15:8]),
      .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
      .serial_rx_en(serial_rx_en), .serial_rx_oe(rx_oe),
      .serial_rx_out(1'b0), .usart_rx_or_sync_data(rx_data),
      .serial_tx_en(fen[6]), .serial_tx_oe(fen[6]),
      .serial_tx_out(fval[6]), .usart_tx_or_sync_clock(tx_clk),
      .spi1_out_en(fen[0]), .spi1_data_out(fval[0]),
      .spi1_select_en(spi1_select_en), .spi1_slave_select(sel_in),
      .pwm2_b_en(fen[1]), .pwm2_out_b(fval[1]), .capture2_en(fen[2]),
      .capture2_oe(fen[2]), .capture2_out(fval[2]),
      .capture_pwm2_out_a(cap2_in), .pwm1_d_en(fen[3]),
      .pwm1_out_d(fval[3]), .pwm1_c_en(fen[4]), .pwm1_out_c(fval[4]),
      .capture1_en(fen[5]), .capture1_oe(fen[5]),
      .capture1_out(fval[5]), .capture_pwm1_out_a(cap1_in));

   iops_pin_env u_env (.core_clk(core_clk),
      .dev_out({pb_pin_out, pa_pin_out}), .dev_oe({pb_pin_oe, pa_pin_oe}),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // Prints the counts and the verdict, then stops.
   task automatic test_done;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // Compares one value and counts a mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Waits for ready under a bound and ends on the sampling edge.
   task automatic rdy(output logic [31:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_errors++;
            test_done;
         end
         @(negedge core_clk);
      end
      d = hrdata;
      @(posedge core_clk);
   endtask : rdy

   // One single-word bus transfer: address phase, then data phase.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy(q);
      htrans <= 2'h0;
      hwdata <= d;
      rdy(q);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask : rdc

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   // Main sequence.
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rdc(PA_DIR_ADDR, 32'hff);
      rdc(PA_LATCH_ADDR, 32'h0);
      rdc(PA_ANSEL_ADDR, 32'h1f);
      rdc(STEER0_ADDR, 32'h0);
      rdc(STEER1_ADDR, 32'h0);
      ext_en <= 16'hffff;
      ext_val <= 16'h005a;
      settle(4);
      chk(32'(pa_digital_in_en), 32'h0);
      rdc(PA_LEVEL_ADDR, 32'h40);
      wr(PA_ANSEL_ADDR, 32'h0);
      settle(4);
      chk(32'(pa_digital_in_en), 32'h1f);
      rdc(PA_LEVEL_ADDR, 32'h5a);
      wr(PA_LEVEL_ADDR, 32'h3c);
      rdc(PA_LATCH_ADDR, 32'h1c);
      wr(PA_LATCH_ADDR, 32'ha5);
      rdc(PA_LATCH_ADDR, 32'h85);
      ext_en <= 16'h0;
      wr(PA_ANSEL_ADDR, 32'h1f);
      wr(PA_DIR_ADDR, 32'h0);
      rdc(PA_DIR_ADDR, 32'h20);
      settle(2);
      chk(32'(pa_pin_oe), 32'hdf);
      chk(32'(pa_pin_out & pa_pin_oe), 32'h85);
      wr(PA_DIR_ADDR, 32'hff);
      // Every output function except serial receive on both of its pins.
      for (int i = 0; i < 7; i++) begin
         fen <= 7'(1 << i);
         for (int s = 0; s < 2; s++) begin
            wr(i == 6 ? STEER1_ADDR : STEER0_ADDR, 32'(s << fb[i]));
            settle(2);
            chk(32'({pb_pin_oe, pa_pin_oe}), 32'(1 << (s ? p1[i] : p0[i])));
            chk(32'({pb_pin_out, pa_pin_out} >> (s ? p1[i] : p0[i])) & 1, 1);
         end
         wr(i == 6 ? STEER1_ADDR : STEER0_ADDR, 32'h0);
      end
      rdc(PA_DIR_ADDR, 32'hff);
      fen <= 7'h0;
      // Both steered inputs follow their selected pin.
      for (int j = 0; j < 2; j++) begin
         serial_rx_en <= (j == 0);
         spi1_select_en <= (j == 1);
         ext_en <= 16'hffff;
         ext_val <= 16'(1 << (j ? 13 : 9));
         wr(STEER0_ADDR, 32'h0);
         settle(5);
         chk(32'(insig), 32'h1);
         wr(STEER0_ADDR, 32'(1 << (j ? 5 : 7)));
         settle(5);
         chk(32'(insig), 32'h0);
         ext_val <= 16'(1 << (j ? 5 : 10));
         settle(5);
         chk(32'(insig), 32'h1);
      end
      // Remaining steered inputs and the receive driver on pb_pin1.
      serial_rx_en <= 1'b1;
      rx_oe <= 1'b1;
      ext_val <= 16'h4400;
      wr(STEER0_ADDR, 32'h0);
      settle(5);
      chk(32'({tx_clk, cap2_in, cap1_in}), 32'h6);
      chk(32'({pb_pin_oe[1], pb_pin_out[1]}), 32'h2);
      wr(STEER0_ADDR, 32'h09);
      wr(STEER1_ADDR, 32'h1);
      settle(5);
      chk(32'({tx_clk, cap2_in, cap1_in}), 32'h0);
      ext_val <= 16'h2180;
      settle(5);
      chk(32'({tx_clk, cap2_in, cap1_in}), 32'h7);
      wr(STEER1_ADDR, 32'h0);
      rx_oe <= 1'b0;
      serial_rx_en <= 1'b0;
      spi1_select_en <= 1'b0;
      ext_en <= 16'h0;
      fen <= 7'h09;
      fval <= 7'h7e;
      wr(STEER0_ADDR, 32'h44);
      settle(2);
      chk(32'({pa_pin_oe[6], pa_pin_out[6]}), 32'h2);
      chk(32'(pb_pin_oe[7]), 32'h0);
      rdc(STEER0_ADDR, 32'h44);
      wr(STEER1_ADDR, 32'hff);
      rdc(STEER1_ADDR, 32'h1);
      wr(8'h40, 32'hff);
      rdc(8'h40, 32'h0);
      chk(32'(hresp), 32'h0);
      test_done;
   end
endmodule : testbench
